/* verilog/fcvt_pkg.sv */
// Constants, types and register map of the float to unsigned converter
package fcvt_pkg;
    // Register byte offsets on the Wishbone slave
    localparam logic [7:0] ADR_SRC = 8'h00;
    localparam logic [7:0] ADR_GUARD = 8'h04;
    localparam logic [7:0] ADR_CMD = 8'h08;
    localparam logic [7:0] ADR_DEST = 8'h0c;
    localparam logic [7:0] ADR_STATUS = 8'h10;
    localparam logic [7:0] ADR_IRQ_STAT = 8'h14;
    localparam logic [7:0] ADR_IRQ_MASK = 8'h18;
    // Command register fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_OP_MSB = 1;
    localparam int CMD_GUARDED_BIT = 4;
    localparam int CMD_BUSY_BIT = 8;
    // Status word layout: exception flags and rounding mode
    localparam int FLAG_W = 6;
    localparam int BIT_INEXACT = 1;
    localparam int BIT_BAD_OP = 4;
    localparam int BIT_DENORM_FLUSHED = 5;
    localparam int RM_LSB = 8;
    localparam int RM_MSB = 9;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] STATUS_WMASK = 32'h0000_033f;
    // Interrupt status bits and reset values
    localparam int IRQ_W = 2;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_EXC = 1;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;
    // Single-precision field positions and exponent landmarks
    localparam int SIGN_BIT = 31;
    localparam int EXP_MSB = 30;
    localparam int EXP_LSB = 23;
    localparam int MAN_MSB = 22;
    localparam logic [7:0] EXP_SPECIAL = 8'hff;
    localparam logic [7:0] EXP_SAT = 8'h9f;
    localparam logic [7:0] EXP_INT = 8'h96;
    localparam logic [7:0] EXP_HALF = 8'h7e;

    typedef enum logic [1:0] {
        RM_NEAREST = 2'h0,
        RM_ZERO = 2'h1,
        RM_POS = 2'h2,
        RM_NEG = 2'h3
    } rmode_t;

    typedef enum logic [1:0] {
        OP_FLAGS_SW = 2'h0,
        OP_TRUNC = 2'h1,
        OP_FLAGS_TRUNC = 2'h2
    } op_t;

    // Three-cycle execution, Gray coded
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ISSUED = 2'b01,
        ST_EXEC = 2'b11,
        ST_WB = 2'b10
    } state_t;

    typedef struct packed {
        logic [FLAG_W-1:0] flags;
        logic [31:0] value;
    } conv_t;
endpackage : fcvt_pkg

/* verilog/float_to_unsigned_convert.sv */
// Float to unsigned integer conversion slice with status word and Wishbone registers
// Functional notes
// - Truncating op converts the source float to unsigned and writes the destination.
// - Flags-only ops write the would-be exception flags as a status-layout vector.
// - Flags-only ops never touch the status word exception flags.
// - Status-rounded flags op rounds by the status word rounding mode.
// - Truncating op and its flags op always round toward zero.
// - Flags ops flush a denormal to zero and set denormal-flushed in result.
// - Truncating op flushes a denormal and sets denormal-flushed in the status word.
// - Truncating op raises its exceptions into the status word flags.
// - Status flags are sticky; only a status word write clears them.
// - Status flags update in the same cycle the destination is written.
// - Simultaneous flag updates are ORed with each other and the old value.
// - Guarded truncating op writes destination and flags only when guard bit 0 is one.
// - Guarded flags ops write destination only when guard bit 0 is one.
`timescale 1ns/1ps
module float_to_unsigned_convert (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Wishbone slave
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [7:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    // Flag updates from other floating-point units
    input wire logic OTHER_VLD,
    input wire logic [fcvt_pkg::FLAG_W-1:0] OTHER_FLAGS,
    // Status word and interrupt
    output logic [31:0] STATUS_WORD,
    output logic IRQ
);
    import fcvt_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Functions

    // Byte-lane merge of a register write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = dat[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    // Float to unsigned conversion with flags
    function automatic conv_t convert(input logic [31:0] f, input rmode_t rm);
        logic [7:0] e;
        logic [22:0] frac;
        logic [55:0] t;
        logic [31:0] ip;
        logic g;
        logic s;
        logic inc;
        conv_t r;
        e = f[EXP_MSB:EXP_LSB];
        frac = f[MAN_MSB:0];
        t = {1'b1, frac, 32'h0000_0000};
        ip = 32'h0000_0000;
        g = 1'b0;
        s = 1'b0;
        inc = 1'b0;
        r = '0;
        if (e == EXP_SPECIAL && frac != 23'h0) begin
            r.flags[BIT_BAD_OP] = 1'b1;
        end else if (e == EXP_SPECIAL) begin
            r.flags[BIT_BAD_OP] = 1'b1;
            r.value = f[SIGN_BIT] ? 32'h0000_0000 : 32'hffff_ffff;
        end else if (e == 8'h00) begin
            r.flags[BIT_DENORM_FLUSHED] = (frac != 23'h0);
        end else if (f[SIGN_BIT]) begin
            r.flags[BIT_BAD_OP] = 1'b1;
        end else if (e >= EXP_SAT) begin
            r.flags[BIT_BAD_OP] = 1'b1;
            r.value = 32'hffff_ffff;
        end else begin
            if (e >= EXP_INT) begin
                ip = 32'(t[55:32]) << (e - EXP_INT);
            end else if (e >= EXP_HALF) begin
                t = t >> (EXP_INT - e);
                ip = 32'(t[55:32]);
                g = t[31];
                s = |t[30:0];
            end else begin
                s = 1'b1;
            end
            // Positive values only: toward-minus equals toward-zero
            case (rm)
                RM_NEAREST: inc = g & (s | ip[0]);
                RM_POS: inc = g | s;
                default: inc = 1'b0;
            endcase
            r.value = ip + 32'(inc);
            r.flags[BIT_INEXACT] = g | s;
        end
        return r;
    endfunction : convert

    ////////////////////////////////////////////////////////////////////////
    // State

    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic [31:0] src_q, src_d;
    logic [31:0] guard_q, guard_d;
    logic [31:0] dest_q, dest_d;
    logic [31:0] status_q, status_d;
    logic [IRQ_W-1:0] irq_stat_q, irq_stat_d;
    logic [IRQ_W-1:0] irq_mask_q, irq_mask_d;
    state_t state_q, state_d;
    op_t op_q, op_d;
    logic wr_en_q, wr_en_d;
    rmode_t rm_q, rm_d;
    conv_t res_q, res_d;
    logic acc;
    logic wr;
    logic go;
    logic wb;
    logic [FLAG_W-1:0] trunc_set;
    logic [1:0] cmd_op;

    // Bus decode and issue condition
    assign acc = CYC_I & STB_I & ~ack_q;
    assign wr = acc & WE_I;
    assign cmd_op = DAT_I[CMD_OP_MSB:CMD_OP_LSB];
    assign go = wr && ADR_I == ADR_CMD && SEL_I[0] && state_q == ST_IDLE && cmd_op != 2'h3;
    assign wb = state_q == ST_WB;
    assign trunc_set = (wb && wr_en_q && op_q == OP_TRUNC) ? res_q.flags : '0;

    ////////////////////////////////////////////////////////////////////////
    // Execution sequence

    // Issue, two execute stages, writeback on the third edge
    always_comb begin
        state_d = state_q;
        op_d = op_q;
        wr_en_d = wr_en_q;
        rm_d = rm_q;
        res_d = res_q;
        case (state_q)
            ST_IDLE: begin
                if (go) begin
                    state_d = ST_ISSUED;
                    op_d = op_t'(cmd_op);
                    wr_en_d = ~DAT_I[CMD_GUARDED_BIT] | guard_q[0];
                    rm_d = (op_t'(cmd_op) == OP_FLAGS_SW) ? rmode_t'(status_q[RM_MSB:RM_LSB]) : RM_ZERO;
                    res_d = convert(src_q, rm_d);
                end
            end
            ST_ISSUED: state_d = ST_EXEC;
            ST_EXEC: state_d = ST_WB;
            ST_WB: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    // Execution registers
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_q <= ST_IDLE;
            op_q <= OP_FLAGS_SW;
            wr_en_q <= 1'b0;
            rm_q <= RM_NEAREST;
            res_q <= '0;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            wr_en_q <= wr_en_d;
            rm_q <= rm_d;
            res_q <= res_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers, writeback and status word

    // Bus writes, writeback, sticky flag merge and interrupt status
    always_comb begin
        ack_d = acc;
        rdata_d = 32'h0000_0000;
        src_d = src_q;
        guard_d = guard_q;
        dest_d = dest_q;
        status_d = status_q;
        irq_mask_d = irq_mask_q;
        irq_stat_d = irq_stat_q;
        if (acc && !WE_I) begin
            case (ADR_I)
                ADR_SRC: rdata_d = src_q;
                ADR_GUARD: rdata_d = guard_q;
                ADR_CMD: rdata_d = {23'h0, state_q != ST_IDLE, 8'h00};
                ADR_DEST: rdata_d = dest_q;
                ADR_STATUS: rdata_d = status_q;
                ADR_IRQ_STAT: rdata_d = {30'h0, irq_stat_q};
                ADR_IRQ_MASK: rdata_d = {30'h0, irq_mask_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
        if (wr) begin
            case (ADR_I)
                ADR_SRC: src_d = merge(src_q, DAT_I, SEL_I);
                ADR_GUARD: guard_d = merge(guard_q, DAT_I, SEL_I);
                ADR_STATUS: status_d = merge(status_q, DAT_I, SEL_I) & STATUS_WMASK;
                ADR_IRQ_MASK: irq_mask_d = SEL_I[0] ? DAT_I[IRQ_W-1:0] : irq_mask_q;
                ADR_IRQ_STAT: irq_stat_d = irq_stat_q & ~(SEL_I[0] ? DAT_I[IRQ_W-1:0] : 2'h0);
                default: ;
            endcase
        end
        if (wb && wr_en_q) begin
            dest_d = (op_q == OP_TRUNC) ? res_q.value : {26'h0, res_q.flags};
        end
        // Sets win over a same-cycle software write
        status_d[FLAG_W-1:0] = status_d[FLAG_W-1:0] | trunc_set;
        if (OTHER_VLD) begin
            status_d[FLAG_W-1:0] = status_d[FLAG_W-1:0] | OTHER_FLAGS;
        end
        irq_stat_d[IRQ_DONE] = irq_stat_d[IRQ_DONE] | wb;
        irq_stat_d[IRQ_EXC] = irq_stat_d[IRQ_EXC] | (trunc_set != '0);
    end

    // Register file
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            src_q <= 32'h0000_0000;
            guard_q <= 32'h0000_0000;
            dest_q <= 32'h0000_0000;
            status_q <= STATUS_RESET;
            irq_stat_q <= IRQ_RESET;
            irq_mask_q <= IRQ_RESET;
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            src_q <= src_d;
            guard_q <= guard_d;
            dest_q <= dest_d;
            status_q <= status_d;
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
        end
    end

    // Outputs
    assign ACK_O = ack_q;
    assign DAT_O = rdata_q;
    assign STATUS_WORD = status_q;
    assign IRQ = |(irq_stat_q & irq_mask_q);

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    logic sw_status_wr;
    assign sw_status_wr = wr && ADR_I == ADR_STATUS;

    chk_flags_keep_status: assert property (@(posedge CLK) disable iff (!RST_N)
        wb && op_q != OP_TRUNC && !sw_status_wr && !OTHER_VLD |=> $stable(status_q))
        else $error("flags-only op changed status word");

    chk_guard_holds_dest: assert property (@(posedge CLK) disable iff (!RST_N)
        wb && !wr_en_q |=> $stable(dest_q) && ($past(sw_status_wr || OTHER_VLD) || $stable(status_q)))
        else $error("false guard changed destination");

    chk_trunc_value: assert property (@(posedge CLK) disable iff (!RST_N)
        go && cmd_op == OP_TRUNC && !DAT_I[CMD_GUARDED_BIT] ##3 1'b1 |=> dest_q == $past(res_q.value, 1))
        else $error("truncating result not written");

    chk_flag_vector: assert property (@(posedge CLK) disable iff (!RST_N)
        wb && wr_en_q && op_q != OP_TRUNC |=> dest_q == {26'h0, $past(res_q.flags)})
        else $error("flag vector not written");

    chk_rounding_mode: assert property (@(posedge CLK) disable iff (!RST_N)
        state_q == ST_ISSUED && op_q != OP_FLAGS_SW |-> rm_q == RM_ZERO)
        else $error("truncating op not rounding to zero");

    chk_status_mode: assert property (@(posedge CLK) disable iff (!RST_N)
        state_q == ST_IDLE && go && cmd_op == OP_FLAGS_SW |=> rm_q == $past(status_q[RM_MSB:RM_LSB]))
        else $error("status rounding mode not used");

    chk_denorm_flush: assert property (@(posedge CLK) disable iff (!RST_N)
        state_q == ST_IDLE && go && src_q[EXP_MSB:EXP_LSB] == 8'h00 && src_q[MAN_MSB:0] != 23'h0
        |=> res_q.value == 32'h0 && res_q.flags == 6'h20)
        else $error("denormal not flushed");

    chk_sticky_flags: assert property (@(posedge CLK) disable iff (!RST_N)
        !sw_status_wr |=> (status_q[FLAG_W-1:0] & $past(status_q[FLAG_W-1:0])) == $past(status_q[FLAG_W-1:0]))
        else $error("sticky flag cleared");

    chk_same_cycle_set: assert property (@(posedge CLK) disable iff (!RST_N)
        wb && wr_en_q && op_q == OP_TRUNC |=> (status_q[FLAG_W-1:0] & $past(res_q.flags)) == $past(res_q.flags))
        else $error("flags not set with writeback");

    chk_or_merge: assert property (@(posedge CLK) disable iff (!RST_N)
        OTHER_VLD |=> (status_q[FLAG_W-1:0] & $past(OTHER_FLAGS)) == $past(OTHER_FLAGS))
        else $error("simultaneous update lost");

    chk_nan_invalid: assert property (@(posedge CLK) disable iff (!RST_N)
        go && src_q[EXP_MSB:EXP_LSB] == EXP_SPECIAL && src_q[MAN_MSB:0] != 23'h0
        |=> res_q.value == 32'h0 && res_q.flags == 6'h10)
        else $error("NaN not invalid");

    chk_writeback_latency: assert property (@(posedge CLK) disable iff (!RST_N)
        go |=> state_q == ST_ISSUED ##1 state_q == ST_EXEC ##1 state_q == ST_WB)
        else $error("writeback not on third edge");
endmodule : float_to_unsigned_convert

/* verification/fp_peer_model.sv */
// Model of a neighbouring floating-point unit posting flag updates
`timescale 1ns/1ps
module fp_peer_model (
    // Clock
    input wire logic clk,
    // Command from the bench
    input wire logic go,
    input wire logic [5:0] go_flags,
    // Flag update towards the converter
    output logic vld,
    output logic [5:0] flags
);
    ////////////////////////////////////////////////////////////////
    // Outside an update the flag lines show the inverse, so stale values never look valid
    always @(posedge clk) begin
        vld <= go;
        flags <= go ? go_flags : ~go_flags;
    end
endmodule : fp_peer_model

/* verification/testbench.sv */
// Self-checking bench for the float to unsigned converter slice
`timescale 1ns/1ps
module testbench;
    import fcvt_pkg::*;
    logic clk, rst_n, cyc, stb, we, ack, vld, irq, go;
    logic [7:0] adr;
    logic [3:0] sel, lanes;
    logic [31:0] wdat, rdat, q, sw;
    logic [5:0] oflags, go_flags;
    int num_errors = 0;
    int tests_run = 0;
    // Source float, expected integer and expected flag vector per case
    logic [31:0] v_src [10] = '{32'h40400000, 32'h40247ae1, 32'hff4fffff, 32'h7f800000, 32'hbfc147ae,
        32'h00400000, 32'h7fc00000, 32'hffbfffff, 32'h4f800000, 32'h4f7fffff};
    logic [31:0] v_val [10] = '{32'h3, 32'h2, 32'h0, 32'hffffffff, 32'h0, 32'h0, 32'h0, 32'h0,
        32'hffffffff, 32'hffffff00};
    logic [5:0] v_flg [10] = '{6'h00, 6'h02, 6'h10, 6'h10, 6'h10, 6'h20, 6'h10, 6'h10, 6'h10, 6'h00};

    ////////////////////////////////////////////////////////////////
    // Design and neighbouring unit
    float_to_unsigned_convert dut (.CLK(clk), .RST_N(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
        .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .OTHER_VLD(vld),
        .OTHER_FLAGS(oflags), .STATUS_WORD(sw), .IRQ(irq));
    fp_peer_model peer (.clk(clk), .go(go), .go_flags(go_flags), .vld(vld), .flags(oflags));

    // Clock at 125 MHz
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Counts and verdict
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    // Classic Wishbone cycle, held until ack is sampled; read data lands in q
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= lanes;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        check("bus ack", 32'h1, {31'h0, ack});
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : bus

    // Issue one operation, poll busy, then read the destination into q
    task automatic run(input logic [1:0] op, input logic g, input logic [31:0] src);
        int n;
        n = 0;
        bus(1'b1, ADR_SRC, src);
        bus(1'b1, ADR_CMD, {27'h0, g, 2'h0, op});
        do begin
            bus(1'b0, ADR_CMD, 32'h0);
            n++;
        end while (q[CMD_BUSY_BIT] !== 1'b0 && n < 10);
        bus(1'b0, ADR_DEST, 32'h0);
    endtask : run

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst_n = 1'b0;
        {cyc, stb, we, go} = 4'h0;
        sel = 4'hf;
        lanes = 4'hf;
        adr = 8'h00;
        wdat = 32'h0;
        go_flags = 6'h00;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b0, ADR_STATUS, 32'h0);
        check("status reset", STATUS_RESET, q);
        check("irq reset", 32'h0, {31'h0, irq});
        // Truncation with rounding mode set toward +inf
        for (int i = 0; i < 10; i++) begin
            bus(1'b1, ADR_STATUS, 32'h200);
            run(OP_TRUNC, 1'b0, v_src[i]);
            check("trunc value", v_val[i], q);
            check("trunc status", {22'h0, 2'h2, 2'h0, v_flg[i]}, sw);
        end
        // Both flags-only ops, status flags must stay clear
        bus(1'b1, ADR_STATUS, 32'h100);
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 10; i++) begin
                run(k ? OP_FLAGS_TRUNC : OP_FLAGS_SW, 1'b0, v_src[i]);
                check("flag vector", {26'h0, v_flg[i]}, q);
                check("flags op status", 32'h100, sw);
            end
        end
        // Sticky accumulation and clear by status write
        bus(1'b1, ADR_STATUS, 32'h0);
        run(OP_TRUNC, 1'b0, v_src[1]);
        run(OP_TRUNC, 1'b0, v_src[0]);
        check("sticky", 32'h02, sw);
        run(OP_TRUNC, 1'b0, v_src[4]);
        check("sticky merge", 32'h12, sw);
        bus(1'b1, ADR_STATUS, 32'h0);
        check("status clear", 32'h0, sw);
        // False guard keeps destination and flags
        bus(1'b1, ADR_GUARD, 32'h0);
        run(OP_TRUNC, 1'b1, v_src[1]);
        check("guard dest", 32'h0, q);
        check("guard status", 32'h0, sw);
        run(OP_FLAGS_TRUNC, 1'b1, v_src[5]);
        check("guard flags dest", 32'h0, q);
        bus(1'b1, ADR_GUARD, 32'h1);
        run(OP_TRUNC, 1'b1, v_src[1]);
        check("guard true dest", 32'h2, q);
        check("guard true status", 32'h2, sw);
        // Neighbour posts a flag across the writeback edge
        bus(1'b1, ADR_STATUS, 32'h0);
        bus(1'b1, ADR_SRC, v_src[1]);
        bus(1'b1, ADR_CMD, {30'h0, OP_TRUNC});
        go <= 1'b1;
        go_flags <= 6'h01;
        repeat (4) @(posedge clk);
        go <= 1'b0;
        repeat (4) @(posedge clk);
        check("merged flags", 32'h03, sw);
        // Interrupt raise, mask and clear
        bus(1'b0, ADR_IRQ_STAT, 32'h0);
        check("irq status", 32'h3, q);
        check("irq masked", 32'h0, {31'h0, irq});
        bus(1'b1, ADR_IRQ_MASK, 32'h1);
        check("irq raised", 32'h1, {31'h0, irq});
        bus(1'b1, ADR_IRQ_STAT, 32'h3);
        check("irq cleared", 32'h0, {31'h0, irq});
        bus(1'b0, ADR_IRQ_STAT, 32'h0);
        check("irq status clear", 32'h0, q);
        bus(1'b0, 8'h1c, 32'h0);
        check("unmapped", 32'h0, q);
        // Byte lanes and refused commands: no lane 0, op code 3
        lanes = 4'h1;
        bus(1'b1, ADR_SRC, 32'h0000_00ff);
        lanes = 4'he;
        bus(1'b1, ADR_CMD, {30'h0, OP_TRUNC});
        lanes = 4'hf;
        bus(1'b0, ADR_CMD, 32'h0);
        check("cmd without lane 0", 32'h0, q);
        bus(1'b1, ADR_CMD, 32'h3);
        bus(1'b0, ADR_CMD, 32'h0);
        check("op code 3 ignored", 32'h0, q);
        bus(1'b0, ADR_SRC, 32'h0);
        check("lane merge", 32'h40247aff, q);
        report_and_stop();
    end

    // Watchdog well beyond the expected run length
    initial begin
        #200000;
        num_errors++;
        report_and_stop();
    end
endmodule : testbench
